// file: core/tih_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 125 MHz clock
// Notes:   Shared by both ends of the converter link
`ifndef TIH_DEFINES_SVH
`define TIH_DEFINES_SVH

// ==========================================================
// Register addresses
`define TIH_ADDR_RESULT   4'h0
`define TIH_ADDR_MAIN     4'h0
`define TIH_ADDR_CALC     4'h2
`define TIH_ADDR_DIV      4'h4
`define TIH_ADDR_DIVAUX   4'h5
`define TIH_ADDR_HITEN    4'h7
`define TIH_ADDR_INIT     4'hb
`define TIH_ADDR_RDPTR    4'he

// ==========================================================
// Field positions
`define TIH_MAIN_RESADJ   1
`define TIH_MAIN_NOISE    2
`define TIH_MAIN_AUTOCAL  3
`define TIH_MAIN_MULT     4
`define TIH_MAIN_CALCLK   5
`define TIH_MAIN_LONG     6
`define TIH_INIT_MEAS     0
`define TIH_INIT_ALU      1
`define TIH_INIT_SOFTPOR  7
`define TIH_DIV_SEL_LSB   5
`define TIH_DIV_LOG2_MAX  3'h6

// ==========================================================
// Reset and command values
`define TIH_RST_BYTE      8'h00
`define TIH_VAL_HITS_OFF  8'h00
`define TIH_VAL_INIT      8'h07
`define TIH_VAL_MAIN      8'h78
`define TIH_VAL_CALC_1    8'h21
`define TIH_VAL_DIV       8'hc0
`define TIH_LFSR_SEED     16'hace1

// ==========================================================
// Timing
`define TIH_CLK_MHZ       125
`define TIH_ALU_NS        3000
`define TIH_ALU_CYC       ((`TIH_ALU_NS * `TIH_CLK_MHZ + 999) / 1000)
`define TIH_POLL_GUARD    2

`endif

// file: core/tih_pkg.sv
// Purpose: Types shared by the converter and its host sequencer
// Assumes: Constants live in tih_defines.svh
// Notes:   One-hot state codes
package tih_pkg;

   typedef logic [31:0] tih_result_t;

   typedef enum logic [3:0] {
      M_IDLE  = 4'h1,
      M_ARMED = 4'h2,
      M_RUN   = 4'h4,
      M_DONE  = 4'h8
   } tih_meas_state_t;

   typedef enum logic [6:0] {
      H_IDLE = 7'h01,
      H_CFG  = 7'h02,
      H_INIT = 7'h04,
      H_POLL = 7'h08,
      H_WAIT = 7'h10,
      H_CALC = 7'h20,
      H_READ = 7'h40
   } tih_host_state_t;

endpackage : tih_pkg

// file: core/tih_if.sv
// Purpose: Byte-wide register port plus completion flag
// Assumes: Single clock shared by both ends
// Notes:   Read data valid only in the cycle after the read strobe
`timescale 1ns/100ps
interface tih_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       completion_flag;

   modport dev  (input addr, input wdata, input wr, input rd, output rdata, output completion_flag);
   modport host (output addr, output wdata, output wr, output rd, input rdata, input completion_flag);
endinterface : tih_if

// file: core/tih_device.sv
// Purpose: Time-interval converter end: measurement, arithmetic unit, result port
// Assumes: Start and stop are asynchronous pins; register port on the local clock
// Notes:   Three results of four bytes each, read through an auto-incrementing index
//
// Overview of operation
// - Measurement done starts selected calculation automatically
// - New calculation select stores next result slot
// - Host waits three microseconds between calculations
// - Four bytes per result, auto-incremented reads
// - Init command 0x07 resets measurement and arithmetic
// - Hit enable zero disables all stops
// - Hit enable value sets accepted stop count
// - Main config 0x78 selects long range, calibration; calibration bits stored but unused
// - Calculation select 0x21 gives first stop minus start
// - Selects 1,2,3 give hits minus start
// - Divider config 0xc0 selects divide by 64
// - Completion flag marks finished measurement
// - Result bytes fraction low first, integer last
// - Start ignored in resolution-adjust mode
// - Software power-on reset via init register
// - Auto-noise adds pseudo jitter without adjust
// - Resolution adjust adds its own dither
// - Divider codes map to 1..64 factors
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "tih_defines.svh"
module tih_device (
   input  wire logic  clk_in,
   input  wire logic  nrst_in,
   tih_if.dev         bus,
   input  wire logic  start_in,
   input  wire logic  stop_in,
   output logic       meas_busy_out,
   output logic       alu_busy_out
);

   // ==========================================================
   // Registers
   logic [7:0]                main_cfg_reg;
   logic [7:0]                calc_sel_reg;
   logic [7:0]                div_cfg_reg;
   logic [7:0]                div_aux_reg;
   logic [7:0]                hit_en_reg;
   logic [3:0]                rd_idx_reg;
   logic [7:0]                rdata_reg;
   logic                      flag_reg;
   logic                      soft_rst_reg;
   tih_pkg::tih_meas_state_t  meas_reg;
   logic [1:0]                hit_cnt_reg;
   logic [15:0]               coarse_reg;
   logic [5:0]                prescale_reg;
   logic [15:0]               lfsr_reg;
   tih_pkg::tih_result_t      start_stamp_reg;
   tih_pkg::tih_result_t      hit_time_reg [3];
   tih_pkg::tih_result_t      result_reg [3];
   logic                      alu_busy_reg;
   logic [8:0]                alu_cnt_reg;
   logic [1:0]                alu_wr_idx_reg;

   logic wr_main, wr_calc, wr_div, wr_divaux, wr_hiten, wr_init, wr_ptr;
   logic init_meas, init_alu, rd_result;
   logic [2:0]  div_log2;
   logic [5:0]  div_last;
   logic        dither_on;
   tih_pkg::tih_result_t stamp;
   tih_pkg::tih_result_t alu_value;
   logic        hit_take, meas_finish, alu_start;
   logic [1:0]  op_idx;

   assign wr_main   = bus.wr && bus.addr == `TIH_ADDR_MAIN;
   assign wr_calc   = bus.wr && bus.addr == `TIH_ADDR_CALC;
   assign wr_div    = bus.wr && bus.addr == `TIH_ADDR_DIV;
   assign wr_divaux = bus.wr && bus.addr == `TIH_ADDR_DIVAUX;
   assign wr_hiten  = bus.wr && bus.addr == `TIH_ADDR_HITEN;
   assign wr_init   = bus.wr && bus.addr == `TIH_ADDR_INIT;
   assign wr_ptr    = bus.wr && bus.addr == `TIH_ADDR_RDPTR;
   assign init_meas = wr_init && bus.wdata[`TIH_INIT_MEAS];
   assign init_alu  = wr_init && bus.wdata[`TIH_INIT_ALU];
   assign rd_result = bus.rd && bus.addr == `TIH_ADDR_RESULT;

   assign bus.rdata           = rdata_reg;
   assign bus.completion_flag = flag_reg;

   // ==========================================================
   // Pin synchronisers: 2nd and 3rd stage must agree
   logic [1:0] pin_raw;
   logic [2:0] sync_reg [2];
   logic       pin_lvl_reg [2];
   logic [1:0] pin_rise;
   assign pin_raw = {stop_in, start_in};

   for (genvar g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            sync_reg[g]    <= 3'h0;
            pin_lvl_reg[g] <= 1'b0;
         end else begin
            sync_reg[g] <= {sync_reg[g][1:0], pin_raw[g]};
            if (sync_reg[g][1] == sync_reg[g][2])
               pin_lvl_reg[g] <= sync_reg[g][2];
         end
      end
      assign pin_rise[g] = (sync_reg[g][1] == sync_reg[g][2]) && sync_reg[g][2] && !pin_lvl_reg[g];
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= wr_init && bus.wdata[`TIH_INIT_SOFTPOR];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         main_cfg_reg <= `TIH_RST_BYTE;
         calc_sel_reg <= `TIH_RST_BYTE;
         div_cfg_reg  <= `TIH_RST_BYTE;
         div_aux_reg  <= `TIH_RST_BYTE;
         hit_en_reg   <= `TIH_RST_BYTE;
      end else if (soft_rst_reg) begin
         main_cfg_reg <= `TIH_RST_BYTE;
         calc_sel_reg <= `TIH_RST_BYTE;
         div_cfg_reg  <= `TIH_RST_BYTE;
         div_aux_reg  <= `TIH_RST_BYTE;
         hit_en_reg   <= `TIH_RST_BYTE;
      end else begin
         if (wr_main)   main_cfg_reg <= bus.wdata;
         if (wr_calc)   calc_sel_reg <= bus.wdata;
         if (wr_div)    div_cfg_reg  <= bus.wdata;
         if (wr_divaux) div_aux_reg  <= bus.wdata;
         if (wr_hiten)  hit_en_reg   <= bus.wdata;
      end
   end

   // ==========================================================
   // Divider, time stamp and dither
   always_comb begin
      div_log2 = div_cfg_reg[`TIH_DIV_SEL_LSB +: 3];
      if (div_log2 > `TIH_DIV_LOG2_MAX)
         div_log2 = `TIH_DIV_LOG2_MAX;
      div_last = 6'((7'h01 << div_log2) - 7'h01);
   end

   assign dither_on = main_cfg_reg[`TIH_MAIN_RESADJ] || main_cfg_reg[`TIH_MAIN_NOISE];

   always_comb begin
      if (!main_cfg_reg[`TIH_MAIN_LONG])
         stamp = {coarse_reg, 16'h0000};
      else if (main_cfg_reg[`TIH_MAIN_MULT])
         stamp = {16'((coarse_reg << div_log2) | 16'(prescale_reg)), 16'h0000};
      else
         stamp = {coarse_reg, 16'(({prescale_reg, 16'h0000}) >> div_log2)};
      if (dither_on)
         stamp[7:0] = stamp[7:0] ^ lfsr_reg[7:0];
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lfsr_reg <= `TIH_LFSR_SEED;
      end else begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end

   // ==========================================================
   // Measurement sequencer
   assign hit_take    = meas_reg == tih_pkg::M_RUN && pin_rise[1] && hit_en_reg != 8'h00
                        && {6'h00, hit_cnt_reg} < hit_en_reg;
   assign meas_finish = meas_reg == tih_pkg::M_RUN
                        && ((hit_take && ({6'h00, hit_cnt_reg} + 8'h01 == hit_en_reg || hit_cnt_reg == 2'h2))
                            || (coarse_reg == 16'hffff && prescale_reg == div_last));

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meas_reg        <= tih_pkg::M_IDLE;
         hit_cnt_reg     <= 2'h0;
         coarse_reg      <= 16'h0000;
         prescale_reg    <= 6'h00;
         start_stamp_reg <= 32'h0000_0000;
         hit_time_reg    <= '{default: 32'h0000_0000};
      end else if (soft_rst_reg) begin
         meas_reg <= tih_pkg::M_IDLE;
      end else if (init_meas) begin
         meas_reg     <= tih_pkg::M_ARMED;
         hit_cnt_reg  <= 2'h0;
         coarse_reg   <= 16'h0000;
         prescale_reg <= 6'h00;
      end else begin
         unique case (meas_reg)
            tih_pkg::M_IDLE: begin
            end
            tih_pkg::M_ARMED: begin
               if (main_cfg_reg[`TIH_MAIN_RESADJ] || pin_rise[0]) begin
                  meas_reg        <= tih_pkg::M_RUN;
                  start_stamp_reg <= stamp;
                  // Start edge is the first tick of the interval
                  if (!main_cfg_reg[`TIH_MAIN_LONG] || div_last == 6'h00)
                     coarse_reg <= 16'h0001;
                  else
                     prescale_reg <= 6'h01;
               end
            end
            tih_pkg::M_RUN: begin
               if (!main_cfg_reg[`TIH_MAIN_LONG] || prescale_reg == div_last) begin
                  prescale_reg <= 6'h00;
                  coarse_reg   <= coarse_reg + 16'h0001;
               end else begin
                  prescale_reg <= prescale_reg + 6'h01;
               end
               if (hit_take) begin
                  hit_time_reg[hit_cnt_reg] <= stamp;
                  hit_cnt_reg               <= hit_cnt_reg + 2'h1;
               end
               if (meas_finish)
                  meas_reg <= tih_pkg::M_DONE;
            end
            tih_pkg::M_DONE: begin
            end
         endcase
      end
   end

   // Set wins over the init clear
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flag_reg <= 1'b0;
      end else if (meas_finish) begin
         flag_reg <= 1'b1;
      end else if (init_meas || soft_rst_reg) begin
         flag_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Arithmetic unit
   assign alu_start = meas_finish
                      || (wr_calc && meas_reg == tih_pkg::M_DONE);
   assign op_idx    = calc_sel_reg[1:0];
   always_comb begin
      alu_value = 32'h0000_0000;
      if (op_idx != 2'h0 && calc_sel_reg[3:2] == 2'h0)
         alu_value = hit_time_reg[op_idx - 2'h1] - start_stamp_reg;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         alu_busy_reg   <= 1'b0;
         alu_cnt_reg    <= 9'h000;
         alu_wr_idx_reg <= 2'h0;
         result_reg     <= '{default: 32'h0000_0000};
      end else if (soft_rst_reg || init_alu) begin
         alu_busy_reg   <= 1'b0;
         alu_wr_idx_reg <= 2'h0;
      end else if (alu_start) begin
         alu_busy_reg <= 1'b1;
         alu_cnt_reg  <= 9'(`TIH_ALU_CYC - 2);
      end else if (alu_busy_reg) begin
         if (alu_cnt_reg == 9'h000) begin
            alu_busy_reg <= 1'b0;
            if (alu_wr_idx_reg != 2'h3) begin
               result_reg[alu_wr_idx_reg] <= alu_value;
               alu_wr_idx_reg             <= alu_wr_idx_reg + 2'h1;
            end
         end else begin
            alu_cnt_reg <= alu_cnt_reg - 9'h001;
         end
      end
   end

   // ==========================================================
   // Read port
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_idx_reg <= 4'h0;
         rdata_reg  <= `TIH_RST_BYTE;
      end else begin
         rdata_reg <= `TIH_RST_BYTE;
         if (soft_rst_reg) begin
            rd_idx_reg <= 4'h0;
         end else if (wr_ptr) begin
            rd_idx_reg <= bus.wdata[3:0];
         end else if (rd_result) begin
            if (rd_idx_reg < 4'hc)
               rdata_reg <= result_reg[rd_idx_reg[3:2]][{rd_idx_reg[1:0], 3'h0} +: 8];
            rd_idx_reg <= rd_idx_reg + 4'h1;
         end else if (bus.rd) begin
            unique case (bus.addr)
               `TIH_ADDR_CALC:   rdata_reg <= calc_sel_reg;
               `TIH_ADDR_DIV:    rdata_reg <= div_cfg_reg;
               `TIH_ADDR_DIVAUX: rdata_reg <= div_aux_reg;
               `TIH_ADDR_HITEN:  rdata_reg <= hit_en_reg;
               `TIH_ADDR_INIT:   rdata_reg <= {4'h0, alu_busy_reg, meas_reg == tih_pkg::M_RUN,
                                               hit_cnt_reg};
               default:          rdata_reg <= `TIH_RST_BYTE;
            endcase
         end
      end
   end

   // ==========================================================
   // User status
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meas_busy_out <= 1'b0;
         alu_busy_out  <= 1'b0;
      end else begin
         meas_busy_out <= meas_reg == tih_pkg::M_RUN || meas_reg == tih_pkg::M_ARMED;
         alu_busy_out  <= alu_busy_reg;
      end
   end

endmodule : tih_device

// file: core/tih_host.sv
// Purpose: Host sequencer: configure, measure, calculate and read results
// Assumes: Register port of tih_if; completion flag on the same clock
// Notes:   One run per run_in pulse; 1 to 3 hits
`timescale 1ns/100ps
`include "tih_defines.svh"
module tih_host (
   input  wire logic          clk_in,
   input  wire logic          nrst_in,
   tih_if.host                bus,
   input  wire logic          run_in,
   input  wire logic [1:0]    hits_in,
   output tih_pkg::tih_result_t result_out,
   output logic               result_valid_out,
   output logic               busy_out
);

   tih_pkg::tih_host_state_t state_reg;
   logic [2:0]  step_reg;
   logic [1:0]  hits_reg;
   logic [1:0]  calc_idx_reg;
   logic [8:0]  wait_cnt_reg;
   logic [3:0]  iss_cnt_reg;
   logic [3:0]  cap_cnt_reg;
   logic        rd_pend_reg;
   logic [23:0] asm_reg;
   logic [3:0]  addr_reg;
   logic [7:0]  wdata_reg;
   logic        wr_reg;
   logic        rd_reg;
   logic [3:0]  byte_total;
   logic [3:0]  cfg_addr;
   logic [7:0]  cfg_data;

   assign bus.addr  = addr_reg;
   assign bus.wdata = wdata_reg;
   assign bus.wr    = wr_reg;
   assign bus.rd    = rd_reg;
   assign byte_total = {hits_reg, 2'h0};

   // ==========================================================
   // Configuration script
   always_comb begin
      unique case (step_reg)
         3'h0:    begin cfg_addr = `TIH_ADDR_HITEN; cfg_data = `TIH_VAL_HITS_OFF; end
         3'h1:    begin cfg_addr = `TIH_ADDR_INIT;  cfg_data = `TIH_VAL_INIT;     end
         3'h2:    begin cfg_addr = `TIH_ADDR_MAIN;  cfg_data = `TIH_VAL_MAIN;     end
         3'h3:    begin
            cfg_addr = `TIH_ADDR_CALC;
            cfg_data = (hits_reg == 2'h1) ? `TIH_VAL_CALC_1 : 8'h01;
         end
         3'h4:    begin cfg_addr = `TIH_ADDR_DIV;   cfg_data = `TIH_VAL_DIV;      end
         default: begin cfg_addr = `TIH_ADDR_HITEN; cfg_data = {6'h00, hits_reg}; end
      endcase
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg    <= tih_pkg::H_IDLE;
         step_reg     <= 3'h0;
         hits_reg     <= 2'h1;
         calc_idx_reg <= 2'h1;
         wait_cnt_reg <= 9'h000;
         iss_cnt_reg  <= 4'h0;
         addr_reg     <= 4'h0;
         wdata_reg    <= 8'h00;
         wr_reg       <= 1'b0;
         rd_reg       <= 1'b0;
      end else begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         unique case (state_reg)
            tih_pkg::H_IDLE: begin
               if (run_in && hits_in != 2'h0) begin
                  hits_reg  <= hits_in;
                  step_reg  <= 3'h0;
                  state_reg <= tih_pkg::H_CFG;
               end
            end
            tih_pkg::H_CFG: begin
               wr_reg    <= 1'b1;
               addr_reg  <= cfg_addr;
               wdata_reg <= cfg_data;
               step_reg  <= step_reg + 3'h1;
               if (step_reg == 3'h5)
                  state_reg <= tih_pkg::H_INIT;
            end
            tih_pkg::H_INIT: begin
               wr_reg       <= 1'b1;
               addr_reg     <= `TIH_ADDR_INIT;
               wdata_reg    <= `TIH_VAL_INIT;
               wait_cnt_reg <= 9'(`TIH_POLL_GUARD);
               state_reg    <= tih_pkg::H_POLL;
            end
            tih_pkg::H_POLL: begin
               if (wait_cnt_reg != 9'h000) begin
                  wait_cnt_reg <= wait_cnt_reg - 9'h001;
               end else if (bus.completion_flag) begin
                  calc_idx_reg <= 2'h1;
                  wait_cnt_reg <= 9'(`TIH_ALU_CYC);
                  state_reg    <= tih_pkg::H_WAIT;
               end
            end
            tih_pkg::H_WAIT: begin
               if (wait_cnt_reg != 9'h000) begin
                  wait_cnt_reg <= wait_cnt_reg - 9'h001;
               end else if (calc_idx_reg < hits_reg) begin
                  state_reg <= tih_pkg::H_CALC;
               end else begin
                  wr_reg      <= 1'b1;
                  addr_reg    <= `TIH_ADDR_RDPTR;
                  wdata_reg   <= 8'h00;
                  iss_cnt_reg <= 4'h0;
                  state_reg   <= tih_pkg::H_READ;
               end
            end
            tih_pkg::H_CALC: begin
               wr_reg       <= 1'b1;
               addr_reg     <= `TIH_ADDR_CALC;
               wdata_reg    <= {6'h00, calc_idx_reg + 2'h1};
               calc_idx_reg <= calc_idx_reg + 2'h1;
               wait_cnt_reg <= 9'(`TIH_ALU_CYC);
               state_reg    <= tih_pkg::H_WAIT;
            end
            tih_pkg::H_READ: begin
               if (iss_cnt_reg != byte_total) begin
                  rd_reg      <= 1'b1;
                  addr_reg    <= `TIH_ADDR_RESULT;
                  iss_cnt_reg <= iss_cnt_reg + 4'h1;
               end else if (cap_cnt_reg == byte_total) begin
                  state_reg <= tih_pkg::H_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Byte capture and word assembly
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_pend_reg      <= 1'b0;
         cap_cnt_reg      <= 4'h0;
         asm_reg          <= 24'h00_0000;
         result_out       <= 32'h0000_0000;
         result_valid_out <= 1'b0;
      end else begin
         rd_pend_reg      <= rd_reg;
         result_valid_out <= 1'b0;
         if (state_reg == tih_pkg::H_WAIT)
            cap_cnt_reg <= 4'h0;
         if (rd_pend_reg) begin
            cap_cnt_reg <= cap_cnt_reg + 4'h1;
            asm_reg     <= {bus.rdata, asm_reg[23:8]};
            if (cap_cnt_reg[1:0] == 2'h3) begin
               result_out       <= {bus.rdata, asm_reg};
               result_valid_out <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= state_reg != tih_pkg::H_IDLE || run_in;
      end
   end

endmodule : tih_host

// file: verification/tih_link_properties.sv
// Purpose: Checker on the register link between host and converter
// Assumes: Signals of tih_if, sampled on clk_in
// Notes:   Instantiated beside the interface, no bind
`timescale 1ns/100ps
`include "tih_defines.svh"
module tih_link_chk (
   input wire logic       clk_in,
   input wire logic       nrst_in,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       completion_flag
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic [9:0] gap_reg;
   wire        calc_wr = wr && addr == `TIH_ADDR_CALC;
   wire        init_wr = wr && addr == `TIH_ADDR_INIT;
   // ==========================================================
   // Cycles since the last write to the calculation select register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) gap_reg <= 10'h3ff;
      else if (calc_wr) gap_reg <= 10'h001;
      else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h001;
   end
   chk_strobe_excl: assert property (!(wr && rd))
      else $error("read and write strobes together");
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_calc_gap: assert property ((calc_wr || rd) |-> gap_reg >= 10'h176)
      else $error("access too soon after calculation start");
   chk_init_code: assert property (init_wr |-> wdata == `TIH_VAL_INIT)
      else $error("wrong init command value");
   chk_init_clear: assert property (init_wr |=> !completion_flag)
      else $error("flag not cleared by init");
   chk_flag_hold: assert property (completion_flag && !init_wr |=> completion_flag)
      else $error("flag dropped without init");
   chk_read_ready: assert property (rd |-> completion_flag && addr == `TIH_ADDR_RESULT)
      else $error("result read before completion");
   chk_ptr_zero: assert property (wr && addr == `TIH_ADDR_RDPTR |-> wdata == 8'h00)
      else $error("read pointer not set to zero");
endmodule : tih_link_chk

// file: verification/tb_top.sv
// Purpose: Self-checking bench joining host and converter
// Assumes: Result integer is clock cycles from start, fraction zero
// Notes:   Stop gaps are random
`timescale 1ns/100ps
module tb_top;
   logic clk_in = 1'b0, nrst_in = 1'b0, run_in = 1'b0, start_in = 1'b0, stop_in = 1'b0;
   logic [1:0] hits_in = 2'h0;
   logic busy_out, result_valid_out, meas_busy_out, alu_busy_out;
   tih_pkg::tih_result_t result_out, exp_q[$];
   int n_errors = 0, check_count = 0;
   tih_if bus ();
   tih_device tih_device_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus(bus), .start_in(start_in),
      .stop_in(stop_in), .meas_busy_out(meas_busy_out), .alu_busy_out(alu_busy_out));
   tih_host tih_host_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus(bus), .run_in(run_in), .hits_in(hits_in),
      .result_out(result_out), .result_valid_out(result_valid_out), .busy_out(busy_out));
   tih_link_chk tih_link_chk_i (.clk_in(clk_in), .nrst_in(nrst_in), .addr(bus.addr), .wdata(bus.wdata),
      .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .completion_flag(bus.completion_flag));
   always #4 clk_in = ~clk_in;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic conclude();
      if (exp_q.size() != 0) n_errors++;
      $display("errors=%0d checks=%0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // ==========================================================
   // Result monitor
   always @(posedge clk_in) begin
      if (result_valid_out === 1'b1) begin
         if (exp_q.size() == 0) check(result_out, ~result_out);
         else check(result_out, exp_q.pop_front());
      end
   end
   // ==========================================================
   // One measurement with h stop hits
   task automatic run_once(input logic [1:0] h);
      int t;
      int d;
      t = 0;
      @(posedge clk_in) run_in <= 1'b1;
      hits_in <= h;
      @(posedge clk_in) run_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      check({31'h0000_0000, meas_busy_out}, 32'h0000_0001);
      start_in <= 1'b1;
      for (int k = 0; k < h; k++) begin
         d = 6 + $urandom % 30;
         t += d;
         exp_q.push_back({16'(t - 3), 16'h0000});
         repeat (d - 3) @(posedge clk_in);
         stop_in <= 1'b1;
         repeat (3) @(posedge clk_in);
         stop_in <= 1'b0;
      end
      start_in <= 1'b0;
      for (t = 0; t < 5000 && busy_out !== 1'b0; t++) @(posedge clk_in);
      if (t == 5000) begin
         n_errors++;
         conclude();
      end
      check({30'h0000_0000, meas_busy_out, alu_busy_out}, 32'h0000_0000);
   endtask : run_once
   initial begin
      void'($urandom(88));
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 6; i++) run_once(2'(i % 3 + 1));
      repeat (10) @(posedge clk_in);
      conclude();
   end
endmodule : tb_top
